// File: conv_if.sv
`timescale 1ns/1ns
`default_nettype none

interface conv_if;
  logic        start;
  logic [31:0] dividend;
  logic [15:0] divisor;
  logic        busy;
  logic        done;
  logic [31:0] quotient;

  modport req (output start, dividend, divisor, input busy, done, quotient);
  modport div (input start, dividend, divisor, output busy, done, quotient);
endinterface

`default_nettype wire

// File: panel_model.sv
`timescale 1ns/1ns
`default_nettype none

module panel_model
#(
  parameter int NCH = 4
)
(
  // channel data from the converter
  input  wire logic [NCH-1:0][15:0] disp_value_q,
  input  wire logic [NCH-1:0]       disp_dash_q,
  // what the four-digit panel shows
  output logic      [NCH-1:0][15:0] shown
);
  // all ones marks the dash pattern; no legal reading reaches it
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      shown[i] = disp_dash_q[i] ? 16'hFFFF : disp_value_q[i];
    end
  end
endmodule

`default_nettype wire

// File: speed_display.sv
// Behaviour
// RULE1: scale zero means frequency, else speed at 60Hz
// RULE2: pole setting 0, 2..10 even, 102..110 even
// RULE3: priority 102..110, then scale, then 2..10
// RULE4: scale zero units per pole setting
// RULE5: nonzero scale units per pole setting
// RULE6: motor speed is frequency times 120 over poles
// RULE7: poles equal setting minus 100 when high
// RULE8: both settings zero assume four poles
// RULE9: machine speed is scale times frequency over 60Hz
// RULE10: resolution 0.01Hz, 1m/min, 1r/min
// RULE11: values above 9999 shown as dashes
// RULE12: scale capped by max frequency bound, 9998
// RULE13: network option forces frequency display
// RULE14: recompute values from current frequency and settings
//
// Added by the designer: the register addresses and the Avalon-MM register port.
`include "speed_map.svh"
`timescale 1ns/1ns
`default_nettype none

module speed_display
  import speed_pkg::*;
#(
  parameter int NCH = 4
)
(
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  // avalon-mm slave
  input  wire logic [4:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output logic      [31:0]           avs_readdata_q,
  output logic                       avs_waitrequest_q,
  // drive frequencies, 0.01 Hz steps
  input  wire logic [15:0]           out_freq,
  input  wire logic [15:0]           set_freq,
  // network option presence pin
  input  wire logic                  net_option_pin,
  // panel values: output, set, running speed, setting
  output logic      [NCH-1:0][15:0]  disp_value_q,
  output unit_e     [NCH-1:0]        disp_unit_q,
  output logic      [NCH-1:0]        disp_dash_q
);

  // settings
  logic [13:0] machine_speed_scale_q, machine_speed_scale_d;
  logic [6:0]  pole_count_select_q,   pole_count_select_d;
  logic [15:0] max_frequency_limit_q, max_frequency_limit_d;
  logic        reject_q,              reject_d;
  logic [31:0] readdata_d;
  logic        waitrequest_d;

  // pin synchroniser
  logic        opt_meta_q;
  logic        net_opt_q;

  // sequencer
  seq_e        st_q,    st_d;
  chan_t       ch_q,    ch_d;
  logic        start_q, start_d;
  logic [31:0] dvd_q,   dvd_d;
  logic [15:0] dsr_q,   dsr_d;
  logic [21:0] snap_q,  snap_d;
  unit_e       unit_q,  unit_d;
  logic [NCH-1:0][15:0] value_d;
  unit_e [NCH-1:0]      uout_d;
  logic [NCH-1:0]       dash_d;

  // freshness of each channel against the current settings
  logic [NCH-1:0]       fresh_q,     fresh_d;
  logic [21:0]          snap_last_q, snap_last_d;

  // decoded settings
  logic        scale_nz;
  logic        pole_lo;
  logic        pole_hi;
  logic [6:0]  poles;
  logic [15:0] freq_sel;
  logic [21:0] snap_now;
  unit_e       unit_w [NCH];

  // bus helpers
  logic        bus_first;
  logic        wr_commit;
  logic [31:0] scale_prod;
  logic [31:0] maxf_prod;
  logic [31:0] scale_limit;
  logic        scale_ok;
  logic        pole_ok;
  logic        maxf_ok;
  logic [6:0]  pole_wr;

  conv_if cv ();

  speed_div u_div (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .cv      (cv.div)
  );

  // pin is asynchronous to clk_sys
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      opt_meta_q <= 1'b0;
      net_opt_q  <= 1'b0;
    end else begin
      opt_meta_q <= net_option_pin;
      net_opt_q  <= opt_meta_q;
    end
  end

  assign scale_nz = (machine_speed_scale_q != 14'h0000);
  assign pole_lo  = (pole_count_select_q >= `POLE_LO_MIN)
                 && (pole_count_select_q <= `POLE_LO_MAX);
  assign pole_hi  = (pole_count_select_q >= `POLE_HI_MIN);

  // effective pole count for r/min conversion
  always_comb begin
    if (pole_hi) begin
      poles = pole_count_select_q - `POLE_OFFSET; // [RULE7]
    end else if (pole_lo) begin
      poles = pole_count_select_q;
    end else begin
      poles = `POLE_DEFAULT; // [RULE8]
    end
  end

  // unit per channel; channel 2 is the running speed monitor
  for (genvar c = 0; c < NCH; c++) begin : g_unit
    if (c == 2) begin : g_run
      assign unit_w[c] = net_opt_q ? UNIT_HZ : // [RULE13]
                         pole_hi   ? UNIT_RPM : // [RULE3]
                         scale_nz  ? UNIT_MACH : // [RULE5]
                                     UNIT_RPM; // [RULE4]
    end else begin : g_freq
      assign unit_w[c] = net_opt_q ? UNIT_HZ : // [RULE13]
                         pole_hi   ? (scale_nz ? UNIT_HZ : UNIT_RPM) : // [RULE3] [RULE4] [RULE5]
                         (scale_nz && pole_lo) ? UNIT_MACH : // [RULE1] [RULE5]
                                     UNIT_HZ; // [RULE1] [RULE4]
    end
  end

  // output and running speed follow the output frequency
  assign freq_sel = ch_q[0] ? set_freq : out_freq;
  assign snap_now = {net_opt_q, pole_count_select_q, machine_speed_scale_q};

  // round-robin conversion of the four panel values
  always_comb begin
    st_d    = st_q;
    ch_d    = ch_q;
    start_d = 1'b0;
    dvd_d   = dvd_q;
    dsr_d   = dsr_q;
    snap_d  = snap_q;
    unit_d  = unit_q;
    value_d = disp_value_q;
    uout_d  = disp_unit_q;
    dash_d  = disp_dash_q;
    unique case (st_q)
      SEQ_ISSUE: begin
        unit_d = unit_w[ch_q];
        snap_d = snap_now;
        if (unit_w[ch_q] == UNIT_HZ) begin
          // 0.01 Hz steps shown as is
          value_d[ch_q] = freq_sel; // [RULE10]
          uout_d[ch_q]  = UNIT_HZ;
          dash_d[ch_q]  = (freq_sel > `PANEL_MAX); // [RULE11]
          ch_d          = ch_q + 2'h1; // [RULE14]
        end else begin
          start_d = 1'b1;
          st_d    = SEQ_WAIT;
          if (unit_w[ch_q] == UNIT_RPM) begin
            dvd_d = 32'(freq_sel) * 32'(`RPM_FACTOR); // [RULE6]
            dsr_d = 16'(poles) * `CENTI_PER_HZ; // [RULE6] [RULE10]
          end else begin
            dvd_d = 32'(freq_sel) * 32'(machine_speed_scale_q); // [RULE9]
            dsr_d = `REF_FREQ_CENTI; // [RULE9]
          end
        end
      end
      SEQ_WAIT: begin
        if (cv.done) begin
          st_d = SEQ_ISSUE;
          // settings moved during division: redo, never publish stale
          if (snap_q == snap_now) begin // [RULE14]
            value_d[ch_q] = cv.quotient[15:0]; // [RULE10]
            uout_d[ch_q]  = unit_q;
            dash_d[ch_q]  = (cv.quotient > 32'(`PANEL_MAX)); // [RULE11]
            ch_d          = ch_q + 2'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q         <= SEQ_ISSUE;
      ch_q         <= '0;
      start_q      <= 1'b0;
      dvd_q        <= '0;
      dsr_q        <= 16'h0001;
      snap_q       <= '0;
      unit_q       <= UNIT_HZ;
      disp_value_q <= '0;
      disp_unit_q  <= {NCH{UNIT_HZ}};
      disp_dash_q  <= '0;
    end else begin
      st_q         <= st_d;
      ch_q         <= ch_d;
      start_q      <= start_d;
      dvd_q        <= dvd_d;
      dsr_q        <= dsr_d;
      snap_q       <= snap_d;
      unit_q       <= unit_d;
      disp_value_q <= value_d;
      disp_unit_q  <= uout_d;
      disp_dash_q  <= dash_d;
    end
  end

  assign cv.start    = start_q;
  assign cv.dividend = dvd_q;
  assign cv.divisor  = dsr_q;

  // a settings move marks every channel stale until it is republished;
  // software can poll this instead of guessing the sweep time
  always_comb begin
    snap_last_d = snap_now;
    fresh_d     = (snap_now != snap_last_q) ? '0 : fresh_q; // [RULE14]
    unique case (st_q)
      SEQ_ISSUE: begin
        // hz channels publish with the settings of this very cycle
        if (unit_w[ch_q] == UNIT_HZ) begin
          fresh_d[ch_q] = 1'b1;
        end
      end
      SEQ_WAIT: begin
        if (cv.done && (snap_q == snap_now)) begin
          fresh_d[ch_q] = 1'b1; // [RULE14]
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fresh_q     <= '0;
      snap_last_q <= '0;
    end else begin
      fresh_q     <= fresh_d;
      snap_last_q <= snap_last_d;
    end
  end

  // write checks
  assign pole_wr     = avs_writedata[6:0];
  assign scale_limit = `SCALE_BOUND * 32'(`REF_FREQ_CENTI);
  assign scale_prod  = 32'(avs_writedata[13:0]) * 32'(max_frequency_limit_q);
  assign maxf_prod   = 32'(machine_speed_scale_q) * 32'(avs_writedata[15:0]);
  assign scale_ok    = (avs_writedata <= 32'(`SCALE_CAP)) // [RULE12]
                    && (scale_prod < scale_limit); // [RULE12]
  assign maxf_ok     = (avs_writedata[31:16] == 16'h0000)
                    && (avs_writedata[15:0] != 16'h0000)
                    && (maxf_prod < scale_limit); // [RULE12]
  always_comb begin
    pole_ok = 1'b0;
    if (avs_writedata[31:7] == 25'h0000000) begin
      pole_ok = (pole_wr == 7'h00) // [RULE2]
             || (!pole_wr[0] && pole_wr >= `POLE_LO_MIN && pole_wr <= `POLE_LO_MAX)
             || (!pole_wr[0] && pole_wr >= `POLE_HI_MIN && pole_wr <= `POLE_HI_MAX);
    end
  end

  // one wait cycle, then the answer edge
  assign bus_first = (avs_read || avs_write) && avs_waitrequest_q;
  assign wr_commit = avs_write && !avs_waitrequest_q;

  always_comb begin
    machine_speed_scale_d = machine_speed_scale_q;
    pole_count_select_d   = pole_count_select_q;
    max_frequency_limit_d = max_frequency_limit_q;
    reject_d              = reject_q;
    waitrequest_d         = !bus_first;
    readdata_d            = avs_readdata_q;
    if (wr_commit) begin
      unique case (avs_address)
        `REG_SCALE: begin
          reject_d = !scale_ok;
          if (scale_ok) begin
            machine_speed_scale_d = avs_writedata[13:0]; // [RULE1]
          end
        end
        `REG_POLE: begin
          reject_d = !pole_ok;
          if (pole_ok) begin
            pole_count_select_d = pole_wr; // [RULE2]
          end
        end
        `REG_MAXF: begin
          reject_d = !maxf_ok;
          if (maxf_ok) begin
            max_frequency_limit_d = avs_writedata[15:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (bus_first && avs_read) begin
      readdata_d = '0;
      if (avs_address[4] && avs_address[1:0] == 2'h0) begin
        readdata_d[15:0]                          = disp_value_q[avs_address[3:2]];
        readdata_d[`DISP_UNIT_LSB +: 2]           = disp_unit_q[avs_address[3:2]];
        readdata_d[`DISP_DASH_BIT]                = disp_dash_q[avs_address[3:2]];
      end else begin
        unique case (avs_address)
          `REG_SCALE:  readdata_d[13:0] = machine_speed_scale_q;
          `REG_POLE:   readdata_d[6:0]  = pole_count_select_q;
          `REG_MAXF:   readdata_d[15:0] = max_frequency_limit_q;
          `REG_STATUS: begin
            readdata_d[`ST_REJECT] = reject_q;
            readdata_d[`ST_NETOPT] = net_opt_q;
            readdata_d[`ST_BUSY]   = (st_q == SEQ_WAIT) || start_q || cv.busy;
            readdata_d[`ST_STALE]  = !(&fresh_q); // [RULE14]
          end
          default:     readdata_d = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      machine_speed_scale_q <= `SCALE_RST;
      pole_count_select_q   <= `POLE_RST;
      max_frequency_limit_q <= `MAXF_RST;
      reject_q              <= 1'b0;
      avs_waitrequest_q     <= 1'b1;
      avs_readdata_q        <= '0;
    end else begin
      machine_speed_scale_q <= machine_speed_scale_d;
      pole_count_select_q   <= pole_count_select_d;
      max_frequency_limit_q <= max_frequency_limit_d;
      reject_q              <= reject_d;
      avs_waitrequest_q     <= waitrequest_d;
      avs_readdata_q        <= readdata_d;
    end
  end

endmodule

`default_nettype wire

// File: speed_display_properties.sv
`timescale 1ns/1ns
`default_nettype none

module speed_display_properties
  import speed_pkg::*;
#(
  parameter int NCH = 4
)
(
  // clock and reset
  input wire logic                 clk_sys,
  input wire logic                 rst_n,
  // causes
  input wire logic                 avs_write,
  input wire logic [15:0]          out_freq,
  input wire logic [15:0]          set_freq,
  input wire logic                 net_option_pin,
  // panel outputs
  input wire logic [NCH-1:0][15:0] disp_value_q,
  input wire unit_e [NCH-1:0]      disp_unit_q,
  input wire logic [NCH-1:0]       disp_dash_q
);
  logic [15:0] of_q;
  logic [15:0] sf_q;
  logic [9:0]  quiet_q;
  logic [9:0]  quiet_d;
  logic [9:0]  opt_q;
  logic [9:0]  opt_d;
  logic        calm;
  logic        settled;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // refresh takes up to ~150 cycles, so only judge after 300 quiet ones
  always_comb begin
    calm    = (out_freq == of_q) && (set_freq == sf_q) && !avs_write && !net_option_pin;
    quiet_d = !calm ? 10'h000 : (quiet_q == 10'h3FF) ? quiet_q : quiet_q + 10'h001;
    opt_d   = !net_option_pin ? 10'h000 : (opt_q == 10'h3FF) ? opt_q : opt_q + 10'h001;
    settled = calm && (quiet_q >= 10'h12C);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      of_q    <= 16'h0000;
      sf_q    <= 16'h0000;
      quiet_q <= 10'h000;
      opt_q   <= 10'h000;
    end else begin
      of_q    <= out_freq;
      sf_q    <= set_freq;
      quiet_q <= quiet_d;
      opt_q   <= opt_d;
    end
  end

  net_forces_hz_a: assert property (opt_q >= 10'h12C |-> disp_unit_q == '0)
    else $error("option fitted but a channel not in Hz");
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    dash_bound_a: assert property (!disp_dash_q[i] |-> disp_value_q[i] <= 16'h270F)
      else $error("value above panel range without dashes");
  end
  hz_dash_a: assert property (settled && disp_unit_q[0] == UNIT_HZ |-> disp_dash_q[0] == (out_freq > 16'h270F))
    else $error("dash flag wrong for output frequency");
  hz_value_a: assert property (settled && disp_unit_q[0] == UNIT_HZ && !disp_dash_q[0] |-> disp_value_q[0] == out_freq)
    else $error("output frequency value wrong");
  set_value_a: assert property (settled && disp_unit_q[3] == UNIT_HZ && !disp_dash_q[3] |-> disp_value_q[3] == set_freq)
    else $error("setting value wrong");
  hold_values_a: assert property (settled |=> $stable(disp_value_q) && $stable(disp_unit_q))
    else $error("panel changed with no cause");
  speed_unit_a: assert property (settled |-> disp_unit_q[2] != UNIT_HZ)
    else $error("running speed shown in Hz");
  shared_unit_a: assert property (settled |-> disp_unit_q[0] == disp_unit_q[1] && disp_unit_q[0] == disp_unit_q[3])
    else $error("frequency channels disagree on unit");
  unit_priority_a: assert property (settled |-> !(disp_unit_q[2] == UNIT_RPM && disp_unit_q[0] == UNIT_MACH))
    else $error("unit priority broken");
endmodule

bind speed_display speed_display_properties #(.NCH(NCH)) i_props (
  .clk_sys        (clk_sys),
  .rst_n          (rst_n),
  .avs_write      (avs_write),
  .out_freq       (out_freq),
  .set_freq       (set_freq),
  .net_option_pin (net_option_pin),
  .disp_value_q   (disp_value_q),
  .disp_unit_q    (disp_unit_q),
  .disp_dash_q    (disp_dash_q)
);

`default_nettype wire

// File: speed_display_unit_converter_test.sv
`include "speed_map.svh"
`timescale 1ns/1ns
`default_nettype none

module speed_display_unit_converter_test
  import speed_pkg::*;
;
  logic             clk_sys;
  logic             rst_n;
  logic [4:0]       avs_address;
  logic             avs_read;
  logic             avs_write;
  logic [31:0]      avs_writedata;
  logic [31:0]      avs_readdata_q;
  logic             avs_waitrequest_q;
  logic [15:0]      out_freq;
  logic [15:0]      set_freq;
  logic             net_option_pin;
  logic [3:0][15:0] disp_value_q;
  unit_e [3:0]      disp_unit_q;
  logic [3:0]       disp_dash_q;
  logic [3:0][15:0] shown;
  logic [31:0]      rd;
  int               miscompares = 0;
  int               n_tests = 0;
  int               cyc = 0;
  int               pl[11] = '{0, 2, 4, 6, 8, 10, 102, 104, 106, 108, 110};
  int               sc[3] = '{0, 1800, 9998};

  speed_display #(.NCH(4)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata_q(avs_readdata_q),
    .avs_waitrequest_q(avs_waitrequest_q), .out_freq(out_freq), .set_freq(set_freq),
    .net_option_pin(net_option_pin), .disp_value_q(disp_value_q), .disp_unit_q(disp_unit_q),
    .disp_dash_q(disp_dash_q));

  panel_model #(.NCH(4)) i_panel (.disp_value_q(disp_value_q), .disp_dash_q(disp_dash_q), .shown(shown));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // a bus wait can hang forever; the whole run fits well inside this
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do @(posedge clk_sys); while (avs_waitrequest_q !== 1'b0);
    rd = avs_readdata_q;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  // 0 Hz, 1 r/min, 2 machine speed
  function automatic int unit_of(int c, int s, int p, bit opt);
    if (opt) return 0;
    if (s == 0) return (p >= 102 || c == 2) ? 1 : 0;
    if (p >= 102) return (c == 2) ? 1 : 0;
    return (p == 0 && c != 2) ? 0 : 2;
  endfunction

  function automatic int shown_of(int c, int s, int p, bit opt);
    int f;
    int u;
    int v;
    int poles;
    f = (c == 1 || c == 3) ? int'(set_freq) : int'(out_freq);
    u = unit_of(c, s, p, opt);
    poles = (p >= 102) ? p - 100 : (p == 0) ? 4 : p;
    v = (u == 0) ? f : (u == 1) ? f * 120 / (poles * 100) : s * f / 6000;
    return (v > 9999) ? 'hFFFF : v;
  endfunction

  task automatic check_all(int s, int p, bit opt);
    repeat (400) @(posedge clk_sys);
    for (int c = 0; c < 4; c++) begin
      chk(32'(shown[c]), 32'(shown_of(c, s, p, opt)));
      chk(32'(disp_unit_q[c]), 32'(unit_of(c, s, p, opt)));
    end
    bus(1'b0, `REG_DISP_BASE + 5'h08, '0);
    chk(32'(rd[17:16]), 32'(unit_of(2, s, p, opt)));
    bus(1'b0, `REG_STATUS, '0);
    chk(32'(rd[`ST_STALE]), 32'h0);
  endtask

  initial begin
    rst_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    out_freq = 16'h1770;
    set_freq = 16'h0BB8;
    net_option_pin = 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    bus(1'b0, `REG_SCALE, '0);
    chk(rd, 32'h0);
    bus(1'b0, `REG_POLE, '0);
    chk(rd, 32'h4);
    bus(1'b0, `REG_MAXF, '0);
    chk(rd, 32'h2EE0);
    bus(1'b0, 5'h02, '0);
    chk(rd, 32'h0);
    check_all(0, 4, 1'b0);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      out_freq <= k ? 16'h2EE0 : 16'h1770;
      set_freq <= k ? 16'h0309 : 16'h0BB8;
      foreach (sc[i]) foreach (pl[j]) begin
        bus(1'b1, `REG_SCALE, 32'(sc[i]));
        bus(1'b1, `REG_POLE, 32'(pl[j]));
        bus(1'b0, `REG_POLE, '0);
        chk(rd, 32'(pl[j]));
        bus(1'b0, `REG_STATUS, '0);
        chk(32'(rd[`ST_STALE]), 32'h1);
        check_all(sc[i], pl[j], 1'b0);
      end
    end
    // refused writes keep the old value and raise the reject flag
    bus(1'b1, `REG_POLE, 32'h3);
    bus(1'b0, `REG_STATUS, '0);
    chk(32'(rd[0]), 32'h1);
    bus(1'b0, `REG_POLE, '0);
    chk(rd, 32'h6E);
    bus(1'b1, `REG_SCALE, 32'h270F);
    bus(1'b0, `REG_SCALE, '0);
    chk(rd, 32'h270E);
    bus(1'b1, `REG_SCALE, 32'h0);
    bus(1'b1, `REG_MAXF, 32'h9C40);
    bus(1'b1, `REG_SCALE, 32'h2667);
    bus(1'b0, `REG_SCALE, '0);
    chk(rd, 32'h0);
    bus(1'b1, `REG_SCALE, 32'h2666);
    bus(1'b0, `REG_SCALE, '0);
    chk(rd, 32'h2666);
    bus(1'b0, `REG_STATUS, '0);
    chk(32'(rd[0]), 32'h0);
    bus(1'b1, `REG_MAXF, 32'hC350);
    bus(1'b1, `REG_MAXF, 32'h0);
    bus(1'b0, `REG_MAXF, '0);
    chk(rd, 32'h9C40);
    bus(1'b1, `REG_SCALE, 32'h708);
    bus(1'b1, `REG_POLE, 32'h4);
    @(posedge clk_sys);
    net_option_pin <= 1'b1;
    check_all(1800, 4, 1'b1);
    bus(1'b0, `REG_STATUS, '0);
    chk(32'(rd[1]), 32'h1);
    @(posedge clk_sys);
    net_option_pin <= 1'b0;
    check_all(1800, 4, 1'b0);
    give_verdict();
  end
endmodule

`default_nettype wire

// File: speed_div.sv
`timescale 1ns/1ns
`default_nettype none

module speed_div
  import speed_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // conversion request
  conv_if.div      cv
);

  div_e        st_q,   st_d;
  logic [16:0] rem_q,  rem_d;
  logic [31:0] quo_q,  quo_d;
  logic [15:0] dsr_q,  dsr_d;
  logic [4:0]  cnt_q,  cnt_d;
  logic        done_q, done_d;
  logic [16:0] trial;

  // restoring division, one quotient bit per cycle
  always_comb begin
    st_d   = st_q;
    rem_d  = rem_q;
    quo_d  = quo_q;
    dsr_d  = dsr_q;
    cnt_d  = cnt_q;
    done_d = 1'b0;
    trial  = {rem_q[15:0], quo_q[31]};
    unique case (st_q)
      DIV_IDLE: begin
        if (cv.start) begin
          rem_d = '0;
          quo_d = cv.dividend;
          dsr_d = cv.divisor;
          cnt_d = '0;
          st_d  = DIV_RUN;
        end
      end
      DIV_RUN: begin
        if (trial >= {1'b0, dsr_q}) begin
          rem_d = trial - {1'b0, dsr_q};
          quo_d = {quo_q[30:0], 1'b1};
        end else begin
          rem_d = trial;
          quo_d = {quo_q[30:0], 1'b0};
        end
        cnt_d = cnt_q + 5'h01;
        if (cnt_q == 5'h1F) begin
          st_d   = DIV_IDLE;
          done_d = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q   <= DIV_IDLE;
      rem_q  <= '0;
      quo_q  <= '0;
      dsr_q  <= 16'h0001;
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      rem_q  <= rem_d;
      quo_q  <= quo_d;
      dsr_q  <= dsr_d;
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign cv.busy     = (st_q == DIV_RUN);
  assign cv.done     = done_q;
  assign cv.quotient = quo_q;

endmodule

`default_nettype wire

// File: speed_map.svh
`ifndef SPEED_MAP_SVH
`define SPEED_MAP_SVH

// register byte offsets
`define REG_SCALE      5'h00
`define REG_POLE       5'h04
`define REG_MAXF       5'h08
`define REG_STATUS     5'h0C
`define REG_DISP_BASE  5'h10

// status bit positions
`define ST_REJECT      0
`define ST_NETOPT      1
`define ST_BUSY        2
`define ST_STALE       3

// display read-back fields
`define DISP_UNIT_LSB  16
`define DISP_DASH_BIT  18

// reset values
`define SCALE_RST      14'h0000
`define POLE_RST       7'h04
`define MAXF_RST       16'h2EE0

// conversion constants (frequency in 0.01 Hz)
`define SCALE_CAP      14'h270E
`define PANEL_MAX      16'h270F
`define REF_FREQ_CENTI 16'h1770
`define CENTI_PER_HZ   16'h0064
`define RPM_FACTOR     16'h0078
`define POLE_OFFSET    7'h64
`define POLE_DEFAULT   7'h04
`define POLE_LO_MIN    7'h02
`define POLE_LO_MAX    7'h0A
`define POLE_HI_MIN    7'h66
`define POLE_HI_MAX    7'h6E
`define SCALE_BOUND    32'h0000FFFF

`endif

// File: speed_pkg.sv
package speed_pkg;

  typedef enum logic [1:0] {
    UNIT_HZ   = 2'b00,
    UNIT_RPM  = 2'b01,
    UNIT_MACH = 2'b10
  } unit_e;

  typedef enum logic {
    SEQ_ISSUE = 1'b0,
    SEQ_WAIT  = 1'b1
  } seq_e;

  typedef enum logic {
    DIV_IDLE = 1'b0,
    DIV_RUN  = 1'b1
  } div_e;

  typedef logic [1:0] chan_t;

endpackage
